// ===== arp_pkg.sv
// constants for the converter result readout port
package arp_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int POWERUP_TIME_US = 10;
    localparam int POWERUP_CYCLES = (POWERUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TIME_NS = 5000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] POWERUP_LOAD = CNT_W'(POWERUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

    // data widths
    localparam int RES_W = 14;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int PAD_W = 2;
    localparam int DAT_W = 32;
    localparam int ADR_W = 8;
    localparam int SEL_W = 4;

    // register byte addresses
    localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] ADR_RESULT = 8'h08;
    localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h10;

    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'b1;

    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_SYNC_BIT = 2;
    localparam int STAT_BIPOLAR_BIT = 3;
    localparam int STAT_W = 4;

    // interrupt fields
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LOST_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // synchronised pin vector
    localparam int PIN_TRIG = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_RD = 2;
    localparam int PIN_UBS = 3;
    localparam int PIN_DONE_FLAG_OUTPUT_ENABLE_N = 4;
    localparam int PIN_SYNC = 5;
    localparam int PIN_OFS = 6;
    localparam int PIN_W = 7;
    localparam logic [PIN_W-1:0] PIN_RESET = 7'h17;

    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_CONVERT
    } arp_state_t;
endpackage

// ===== arp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module arp_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins in, filtered levels out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, level_ff;
    logic [W-1:0] nxt_level;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            level_ff <= RESET_VAL;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level_o = level_ff;
endmodule

// ===== arp_readout_port.sv
// result readout and conversion status port of the sampling converter
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module arp_readout_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [arp_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [arp_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [arp_pkg::DAT_W-1:0] wb_dat_i,
    output logic [arp_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // raw straight binary code from the analog converter core
    input wire logic [arp_pkg::RES_W-1:0] conv_code_i,
    // host pins
    input wire logic conv_trigger_n_i,
    input wire logic chip_select_n_i,
    input wire logic read_enable_n_i,
    input wire logic upper_byte_select_i,
    input wire logic done_flag_output_enable_n_i,
    input wire logic timing_mode_sync_i,
    input wire logic offset_strap_pin_i,
    // done flag pin
    output logic conv_done_o,
    output logic conv_done_oe_o,
    // result byte bus pins
    output logic [arp_pkg::BYTE_W-1:0] result_byte_bus_o,
    output logic result_byte_bus_oe_o
);
    logic [arp_pkg::PIN_W-1:0] pin_q;
    arp_pkg::arp_state_t state_ff, nxt_state;
    logic [arp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [arp_pkg::WORD_W-1:0] result_ff, nxt_result;
    logic trig_prev_ff, nxt_trig_prev;
    logic ctrl_en_ff, nxt_ctrl_en;
    logic [arp_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
    logic [arp_pkg::IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
    logic [arp_pkg::IRQ_W-1:0] irq_evt;
    logic irq_ff, nxt_irq;
    logic ack_ff, nxt_ack;
    logic [arp_pkg::DAT_W-1:0] dat_ff, nxt_dat;
    logic done_ff, nxt_done, done_oe_ff, nxt_done_oe;
    logic [arp_pkg::BYTE_W-1:0] bus_ff, nxt_bus;
    logic bus_oe_ff, nxt_bus_oe;
    logic cs_n, rd_n, done_flag_output_enable_n_n, sync_mode, bipolar, nxt_busy;
    logic trig_fall, hw_start, sw_start, start_req, acc, wr;

    // straight binary code from the core into the output word
    function automatic logic [arp_pkg::WORD_W-1:0] format_word(
        input logic [arp_pkg::RES_W-1:0] raw,
        input logic bip
    );
        logic [arp_pkg::RES_W-1:0] code;
        code = raw;
        // flipping the msb gives twos complement extremes
        if (bip) begin
            code[arp_pkg::RES_W-1] = ~raw[arp_pkg::RES_W-1];
        end
        // unipolar passes the straight binary code untouched
        return {code, {arp_pkg::PAD_W{1'b0}}};
    endfunction

    function automatic logic reg_hit(
        input logic [arp_pkg::ADR_W-1:0] adr,
        input logic [arp_pkg::ADR_W-1:0] reg_adr
    );
        return adr == reg_adr;
    endfunction

    // countdown helpers shared by power-up and conversion timing
    function automatic logic cnt_expired(
        input logic [arp_pkg::CNT_W-1:0] cnt
    );
        return cnt == arp_pkg::CNT_ZERO;
    endfunction

    function automatic logic [arp_pkg::CNT_W-1:0] cnt_dec(
        input logic [arp_pkg::CNT_W-1:0] cnt
    );
        return cnt - 1'b1;
    endfunction

    // all host pins come from outside this clock domain
    // a pin change reaches the logic four edges later, the pins one more
    arp_pin_sync #(
        .W(arp_pkg::PIN_W),
        .RESET_VAL(arp_pkg::PIN_RESET)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({offset_strap_pin_i, timing_mode_sync_i, done_flag_output_enable_n_i,
                upper_byte_select_i, read_enable_n_i, chip_select_n_i, conv_trigger_n_i}),
        .level_o(pin_q)
    );

    assign cs_n = pin_q[arp_pkg::PIN_CS];
    assign rd_n = pin_q[arp_pkg::PIN_RD];
    assign done_flag_output_enable_n_n = pin_q[arp_pkg::PIN_DONE_FLAG_OUTPUT_ENABLE_N];
    assign sync_mode = pin_q[arp_pkg::PIN_SYNC];
    assign bipolar = pin_q[arp_pkg::PIN_OFS];

    // ack high blocks a second take of the request it answers
    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    // filtered level: a trigger shorter than two cycles is dropped
    assign trig_fall = trig_prev_ff & ~pin_q[arp_pkg::PIN_TRIG];
    // synchronous mode also needs select low
    assign hw_start = trig_fall & (~sync_mode | ~cs_n);
    assign sw_start = wr & reg_hit(wb_adr_i, arp_pkg::ADR_CTRL)
                      & wb_dat_i[arp_pkg::CTRL_START_BIT];
    assign start_req = (hw_start | sw_start) & ctrl_en_ff;

    // conversion sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_result = result_ff;
        irq_evt = '0;
        // previous filtered trigger level for the edge detector
        nxt_trig_prev = pin_q[arp_pkg::PIN_TRIG];
        unique case (state_ff)
            // starts ignored until the power-up interval ends
            arp_pkg::ST_POWERUP: begin
                if (cnt_expired(cnt_ff)) begin
                    nxt_state = arp_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = cnt_dec(cnt_ff);
                end
            end
            arp_pkg::ST_IDLE: begin
                if (start_req) begin
                    nxt_state = arp_pkg::ST_CONVERT;
                    nxt_cnt = arp_pkg::CONV_LOAD;
                end
            end
            arp_pkg::ST_CONVERT: begin
                irq_evt[arp_pkg::IRQ_LOST_BIT] = start_req;
                if (cnt_expired(cnt_ff)) begin
                    nxt_state = arp_pkg::ST_IDLE;
                    // result loads on the edge done rises
                    // only a finished conversion replaces it
                    nxt_result = format_word(conv_code_i, bipolar);
                    irq_evt[arp_pkg::IRQ_DONE_BIT] = 1'b1;
                end else begin
                    nxt_cnt = cnt_dec(cnt_ff);
                end
            end
            // unused state code falls back to idle
            default: begin
                nxt_state = arp_pkg::ST_IDLE;
            end
        endcase
    end

    assign nxt_busy = (nxt_state == arp_pkg::ST_CONVERT);

    // pin drivers
    always_comb begin
        if (sync_mode) begin
            // drive only with enable and select low
            nxt_done_oe = ~done_flag_output_enable_n_n & ~cs_n;
            nxt_done = ~nxt_busy;
        end else begin
            // open drain pull-down gated by enable
            nxt_done_oe = ~done_flag_output_enable_n_n & nxt_busy;
            nxt_done = 1'b0;
        end
        // bus driven with select and read low
        nxt_bus_oe = ~cs_n & ~rd_n;
        // select low gives upper half of the word
        if (pin_q[arp_pkg::PIN_UBS]) begin
            nxt_bus = nxt_result[arp_pkg::BYTE_W-1:0];
        end else begin
            nxt_bus = nxt_result[arp_pkg::WORD_W-1:arp_pkg::BYTE_W];
        end
    end

    // register writes, interrupt status and level
    always_comb begin
        nxt_ctrl_en = ctrl_en_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr && reg_hit(wb_adr_i, arp_pkg::ADR_CTRL)) begin
            nxt_ctrl_en = wb_dat_i[arp_pkg::CTRL_EN_BIT];
        end
        if (wr && reg_hit(wb_adr_i, arp_pkg::ADR_IRQ_MASK)) begin
            nxt_irq_mask = wb_dat_i[arp_pkg::IRQ_W-1:0];
        end
        if (wr && reg_hit(wb_adr_i, arp_pkg::ADR_IRQ_STAT)) begin
            nxt_irq_stat = irq_stat_ff & ~wb_dat_i[arp_pkg::IRQ_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        nxt_irq_stat = nxt_irq_stat | irq_evt;
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    // read data, one ack per request, unmapped reads zero
    always_comb begin
        nxt_ack = acc;
        nxt_dat = '0;
        if (acc && !wb_we_i) begin
            if (reg_hit(wb_adr_i, arp_pkg::ADR_CTRL)) begin
                nxt_dat[arp_pkg::CTRL_EN_BIT] = ctrl_en_ff;
            end else if (reg_hit(wb_adr_i, arp_pkg::ADR_STATUS)) begin
                nxt_dat[arp_pkg::STAT_BUSY_BIT] = (state_ff == arp_pkg::ST_CONVERT);
                nxt_dat[arp_pkg::STAT_READY_BIT] = (state_ff != arp_pkg::ST_POWERUP);
                nxt_dat[arp_pkg::STAT_SYNC_BIT] = sync_mode;
                nxt_dat[arp_pkg::STAT_BIPOLAR_BIT] = bipolar;
            end else if (reg_hit(wb_adr_i, arp_pkg::ADR_RESULT)) begin
                nxt_dat[arp_pkg::WORD_W-1:0] = result_ff;
            end else if (reg_hit(wb_adr_i, arp_pkg::ADR_IRQ_STAT)) begin
                nxt_dat[arp_pkg::IRQ_W-1:0] = irq_stat_ff;
            end else if (reg_hit(wb_adr_i, arp_pkg::ADR_IRQ_MASK)) begin
                nxt_dat[arp_pkg::IRQ_W-1:0] = irq_mask_ff;
            end
        end
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= arp_pkg::ST_POWERUP;
            cnt_ff <= arp_pkg::POWERUP_LOAD;
            result_ff <= '0;
            trig_prev_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            result_ff <= nxt_result;
            trig_prev_ff <= nxt_trig_prev;
        end
    end

    // register bank and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_en_ff <= arp_pkg::CTRL_EN_RESET;
            irq_stat_ff <= arp_pkg::IRQ_RESET;
            irq_mask_ff <= arp_pkg::IRQ_RESET;
            irq_ff <= 1'b0;
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ctrl_en_ff <= nxt_ctrl_en;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // pin output registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
            done_oe_ff <= 1'b0;
            bus_ff <= '0;
            bus_oe_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            done_oe_ff <= nxt_done_oe;
            bus_ff <= nxt_bus;
            bus_oe_ff <= nxt_bus_oe;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o = irq_ff;
    assign conv_done_o = done_ff;
    assign conv_done_oe_o = done_oe_ff;
    assign result_byte_bus_o = bus_ff;
    assign result_byte_bus_oe_o = bus_oe_ff;
endmodule

// ===== arp_readout_port_assertions.sv
// concurrent checks on the readout port bus and pins
`timescale 1ns/100ps
module arp_readout_port_assertions (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [arp_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // host pins
    input wire logic chip_select_n_i,
    input wire logic read_enable_n_i,
    input wire logic upper_byte_select_i,
    input wire logic done_flag_output_enable_n_i,
    input wire logic timing_mode_sync_i,
    input wire logic conv_done_o,
    input wire logic conv_done_oe_o,
    input wire logic [arp_pkg::BYTE_W-1:0] result_byte_bus_o,
    input wire logic result_byte_bus_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence sync_sel_s;
        (timing_mode_sync_i && !chip_select_n_i && !done_flag_output_enable_n_i)[*8];
    endsequence
    sequence rd_sel_s;
        (!chip_select_n_i && !read_enable_n_i)[*8];
    endsequence
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data without ack");
    bus_drive_a: assert property (rd_sel_s |-> result_byte_bus_oe_o)
        else $error("byte bus not driven while selected");
    bus_float_a: assert property ((chip_select_n_i || read_enable_n_i)[*8] |-> !result_byte_bus_oe_o)
        else $error("byte bus driven while deselected");
    pad_zero_a: assert property (rd_sel_s ##0 upper_byte_select_i[*8] |-> result_byte_bus_o[1:0] == 2'h0)
        else $error("lower byte pad bits not zero");
    async_pull_a: assert property ((!timing_mode_sync_i)[*8] ##0 conv_done_oe_o |-> !conv_done_o)
        else $error("open drain done drives high");
    async_float_a: assert property ((!timing_mode_sync_i && done_flag_output_enable_n_i)[*8] |-> !conv_done_oe_o)
        else $error("done driven with enable high");
    sync_float_a: assert property ((timing_mode_sync_i && chip_select_n_i)[*8] |-> !conv_done_oe_o)
        else $error("sync done driven while deselected");
    sync_drive_a: assert property (sync_sel_s |-> conv_done_oe_o)
        else $error("sync done not driven while enabled");
    done_low_a: assert property (sync_sel_s ##0 $fell(conv_done_o) |=> (!conv_done_o)[*8])
        else $error("done rose early in conversion");
endmodule

bind arp_readout_port arp_readout_port_assertions chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chip_select_n_i(chip_select_n_i), .read_enable_n_i(read_enable_n_i),
    .upper_byte_select_i(upper_byte_select_i), .timing_mode_sync_i(timing_mode_sync_i),
    .done_flag_output_enable_n_i(done_flag_output_enable_n_i), .conv_done_o(conv_done_o),
    .conv_done_oe_o(conv_done_oe_o), .result_byte_bus_o(result_byte_bus_o),
    .result_byte_bus_oe_o(result_byte_bus_oe_o));

// ===== arp_host_model.sv
// host model: byte reads over the pins, resolves the shared lines
`timescale 1ns/100ps
module arp_host_model (
    // clock and device pins
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic done_oe_i,
    input wire logic [7:0] bus_i,
    input wire logic bus_oe_i,
    // host controls and line levels
    output logic cs_n_o,
    output logic rd_n_o,
    output logic ubs_o,
    output logic done_line_o,
    output logic [7:0] bus_line_o
);
    logic [7:0] last;
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        ubs_o = 1'b0;
        last = 8'h00;
    end
    // pull-up on the open drain done line
    assign done_line_o = done_oe_i ? done_i : 1'b1;
    always @(posedge clk_i) if (bus_oe_i) last <= bus_i;
    // released bus shows the inverse of its last value
    assign bus_line_o = bus_oe_i ? bus_i : ~last;
    task automatic select(input logic v);
        @(posedge clk_i);
        cs_n_o <= v;
    endtask
    // select first, byte select only with read released
    task automatic read_byte(input logic u, output logic [7:0] b);
        @(posedge clk_i);
        ubs_o <= u;
        cs_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        b = bus_line_o;
        rd_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic read_word(output logic [15:0] w);
        read_byte(1'b0, w[15:8]);
        read_byte(1'b1, w[7:0]);
    endtask
endmodule

// ===== arp_readout_port_tb_top.sv
// self-checking bench for the readout port
`timescale 1ns/100ps
module arp_readout_port_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, trig_n = 1'b1, eoc_en_n = 1'b0;
    logic sync = 1'b0, strap = 1'b0, ack, irq, done, done_oe, bus_oe, cs_n, rd_n, ubs, done_line;
    logic [7:0] adr = 8'h00, bus, bus_line;
    logic [3:0] sel = 4'h0, lanes = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [13:0] code = 14'h0000;
    logic [15:0] w;
    int num_errors = 0, compares = 0;
    // strap, raw code, expected word
    localparam logic [30:0] ROWS [7] = '{{1'b0, 14'h3fff, 16'hfffc}, {1'b0, 14'h3ffe, 16'hfff8},
        {1'b0, 14'h2000, 16'h8000}, {1'b1, 14'h2000, 16'h0000}, {1'b1, 14'h1fff, 16'hfffc},
        {1'b1, 14'h3fff, 16'h7ffc}, {1'b1, 14'h0000, 16'h8000}};
    always #2 clk_i = ~clk_i;
    arp_readout_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .conv_code_i(code), .conv_trigger_n_i(trig_n),
        .chip_select_n_i(cs_n), .read_enable_n_i(rd_n), .upper_byte_select_i(ubs),
        .done_flag_output_enable_n_i(eoc_en_n), .timing_mode_sync_i(sync),
        .offset_strap_pin_i(strap), .conv_done_o(done), .conv_done_oe_o(done_oe),
        .result_byte_bus_o(bus), .result_byte_bus_oe_o(bus_oe));
    arp_host_model host (.clk_i(clk_i), .done_i(done), .done_oe_i(done_oe), .bus_i(bus),
        .bus_oe_i(bus_oe), .cs_n_o(cs_n), .rd_n_o(rd_n), .ubs_o(ubs),
        .done_line_o(done_line), .bus_line_o(bus_line));
    task automatic complete_run;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t: got %h want %h", $time, s, e);
        end
    endtask
    // waits for ack with no limit of its own; the watchdog ends a hang
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    // trigger held high afterwards so a following pulse is a clean edge
    task automatic pulse;
        @(posedge clk_i);
        trig_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        trig_n <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (done_line !== 1'b0 && n < 40) begin @(posedge clk_i); n++; end
        chk(n < 40, 1'b1);
        while (done_line !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
        chk(n < 2000, 1'b1);
    endtask
    initial begin
        int n;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, arp_pkg::ADR_CTRL, 32'h0);
        chk(q, 32'h1);
        pulse();
        repeat (8) @(posedge clk_i);
        wb(1'b0, arp_pkg::ADR_STATUS, 32'h0);
        chk(q, 32'h0);
        n = 0;
        do wb(1'b0, arp_pkg::ADR_STATUS, 32'h0); while (q[1] !== 1'b1 && ++n < 3000);
        chk(q & 32'h3, 32'h2);
        wb(1'b1, arp_pkg::ADR_IRQ_MASK, 32'h3);
        $display("power-up test done");
        for (int i = 0; i < 7; i++) begin
            strap <= ROWS[i][30];
            code <= ROWS[i][29:16];
            repeat (8) @(posedge clk_i);
            pulse();
            wait_done();
            chk(done_line, 1'b1);
            wb(1'b0, arp_pkg::ADR_RESULT, 32'h0);
            chk(q, {16'h0, ROWS[i][15:0]});
            host.read_word(w);
            chk({16'h0, w}, {16'h0, ROWS[i][15:0]});
        end
        $display("coding table done");
        chk(irq, 1'b1);
        wb(1'b1, arp_pkg::ADR_IRQ_STAT, 32'h3);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        lanes = 4'he;
        wb(1'b1, arp_pkg::ADR_IRQ_MASK, 32'h0);
        lanes = 4'hf;
        wb(1'b0, arp_pkg::ADR_IRQ_MASK, 32'h0);
        chk(q, 32'h3);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        $display("irq test done");
        sync <= 1'b1;
        host.select(1'b1);
        repeat (8) @(posedge clk_i);
        pulse();
        repeat (8) @(posedge clk_i);
        wb(1'b0, arp_pkg::ADR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        chk(done_oe, 1'b0);
        host.select(1'b0);
        repeat (8) @(posedge clk_i);
        chk(done_line, 1'b1);
        chk(done_oe, 1'b1);
        code <= 14'h1234;
        pulse();
        chk(done_line, 1'b0);
        pulse();
        wb(1'b0, arp_pkg::ADR_RESULT, 32'h0);
        chk(q, 32'h8000);
        wait_done();
        wb(1'b0, arp_pkg::ADR_IRQ_STAT, 32'h0);
        chk(q, 32'h3);
        wb(1'b0, arp_pkg::ADR_RESULT, 32'h0);
        chk(q, 32'hc8d0);
        wb(1'b1, arp_pkg::ADR_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        $display("sync mode test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({ack, irq, done_oe, bus_oe}, 4'h0);
        chk(rdat, 32'h0);
        rst_i <= 1'b0;
        wb(1'b0, arp_pkg::ADR_RESULT, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, arp_pkg::ADR_STATUS, 32'h0);
        chk(q & 32'h3, 32'h0);
        $display("mid-run reset test done");
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule
